// [hdl/rtctc_consts.vh]
`ifndef RTCTC_CONSTS_VH
`define RTCTC_CONSTS_VH
// Register indices; the byte address on the bus is four times the index.
`define RTCTC_IDX_MIN      6'h01
`define RTCTC_IDX_HOUR     6'h02
`define RTCTC_IDX_WDAY     6'h03
`define RTCTC_IDX_MDAY     6'h04
`define RTCTC_IDX_MONTH    6'h05
`define RTCTC_IDX_YEAR     6'h06
`define RTCTC_IDX_CTRL     6'h10
// Reset values.
`define RTCTC_RST_MIN      8'h00
`define RTCTC_RST_HOUR     8'h00
`define RTCTC_RST_WDAY     8'h00
`define RTCTC_RST_MDAY     8'h01
`define RTCTC_RST_MONTH    8'h01
`define RTCTC_RST_YEAR     8'h00
// Control register fields.
`define RTCTC_CTRL_H12_BIT 0
`define RTCTC_CTRL_WP_BIT  1
`define RTCTC_CTRL_TICK_BIT 2
// Hour field positions.
`define RTCTC_HOUR_PM_BIT  5
// Timebase: clock rate and tick period.
`define RTCTC_CLK_HZ       25000000
`define RTCTC_TICK_S       1
`define RTCTC_TICK_CYC     (`RTCTC_CLK_HZ * `RTCTC_TICK_S)
// AXI responses.
`define RTCTC_RESP_OKAY    2'h0
`define RTCTC_RESP_SLVERR  2'h2
`endif

// [hdl/rtctc_bcd_ctr.v]
`timescale 1ns/100ps
`default_nettype none
// BCD increment with wrap from max to min.
module rtctc_bcd_ctr (
  // Value in
  input  wire [7:0] val,
  input  wire [7:0] min_val,
  input  wire [7:0] max_val,
  // Results
  output wire [7:0] nxt,
  output wire       wrap
);
  assign wrap = (val >= max_val);
  assign nxt  = wrap ? min_val :
                (val[3:0] == 4'h9) ? {val[7:4] + 4'h1, 4'h0} : {val[7:4], val[3:0] + 4'h1};
endmodule // rtctc_bcd_ctr
`default_nettype wire

// [hdl/rtctc_month_len.v]
`timescale 1ns/100ps
`default_nettype none
// Last day of the month in BCD for years 2000 to 2099.
module rtctc_month_len (
  // Calendar in
  input  wire [7:0] month,
  input  wire [7:0] year,
  // Result
  output reg  [7:0] last_day
);
  wire leap;
  // Years 2000-2099: divisible by four, 2000 included, in BCD.
  assign leap = year[4] ? (year[1:0] == 2'h2) : (year[1:0] == 2'h0);
  always @* begin
    case (month)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end
endmodule // rtctc_month_len
`default_nettype wire

// [hdl/rtctc_regs.v]
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rtctc_consts.vh"
module rtctc_regs #(
  parameter [31:0] TICK_CYC = `RTCTC_TICK_CYC
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Seconds rollover from the timebase
  output reg         minute_tick_q
);
  // ******************************************************
  // Registers
  // ******************************************************
  reg  [7:0]  min_q;
  reg  [7:0]  hour_q;
  reg  [7:0]  wday_q;
  reg  [7:0]  mday_q;
  reg  [7:0]  month_q;
  reg  [7:0]  year_q;
  reg  [2:0]  ctrl_q;
  reg  [31:0] cyc_q;
  reg  [5:0]  sec_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_have_q;
  reg         w_have_q;
  wire        h12;
  wire        wp;
  wire        sec_wrap;
  assign h12 = ctrl_q[`RTCTC_CTRL_H12_BIT];
  assign wp  = ctrl_q[`RTCTC_CTRL_WP_BIT];

  // ******************************************************
  // Timebase
  // ******************************************************
  // Seconds are kept only as a private prescaler for the minute count.
  assign sec_wrap = (cyc_q == TICK_CYC - 32'h1) && (sec_q == 6'h3B);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q <= 32'h0;
      sec_q <= 6'h0;
      minute_tick_q <= 1'b0;
    end else begin
      minute_tick_q <= sec_wrap;
      if (cyc_q == TICK_CYC - 32'h1) begin
        cyc_q <= 32'h0;
        sec_q <= (sec_q == 6'h3B) ? 6'h0 : sec_q + 6'h1;
      end else begin
        cyc_q <= cyc_q + 32'h1;
      end
    end
  end

  // ******************************************************
  // Counter chain
  // ******************************************************
  wire [7:0] min_nxt;
  wire       min_wrap;
  wire [7:0] h24_nxt;
  wire       h24_wrap;
  wire [7:0] h12_nxt;
  wire       h12_wrap;
  wire [7:0] mday_nxt;
  wire       mday_wrap;
  wire [7:0] mon_nxt;
  wire       mon_wrap;
  wire [7:0] yr_nxt;
  wire [7:0] last_day;

  // Each stage steps only in a tick in which every stage below it wraps.
  rtctc_bcd_ctr u_min (
    .val     (min_q),
    .min_val (8'h00),
    .max_val (8'h59),
    .nxt     (min_nxt),
    .wrap    (min_wrap)
  );
  rtctc_bcd_ctr u_h24 (
    .val     (hour_q),
    .min_val (8'h00),
    .max_val (8'h23),
    .nxt     (h24_nxt),
    .wrap    (h24_wrap)
  );
  rtctc_bcd_ctr u_h12 (
    .val     ({3'h0, hour_q[4:0]}),
    .min_val (8'h01),
    .max_val (8'h12),
    .nxt     (h12_nxt),
    .wrap    (h12_wrap)
  );
  rtctc_month_len u_len (
    .month    (month_q),
    .year     (year_q),
    .last_day (last_day)
  );
  rtctc_bcd_ctr u_mday (
    .val     (mday_q),
    .min_val (8'h01),
    .max_val (last_day),
    .nxt     (mday_nxt),
    .wrap    (mday_wrap)
  );
  rtctc_bcd_ctr u_mon (
    .val     (month_q),
    .min_val (8'h01),
    .max_val (8'h12),
    .nxt     (mon_nxt),
    .wrap    (mon_wrap)
  );
  rtctc_bcd_ctr u_yr (
    .val     (year_q),
    .min_val (8'h00),
    .max_val (8'h99),
    .nxt     (yr_nxt),
    .wrap    ()
  );

  // Hour advance and day rollover depend on the format.
  reg  [7:0] hour_nxt;
  reg        day_roll;
  always @* begin
    if (h12) begin
      hour_nxt = {2'h0, hour_q[5], h12_nxt[4:0]};
      day_roll = 1'b0;
      if (hour_q[4:0] == 5'h11) begin
        hour_nxt[`RTCTC_HOUR_PM_BIT] = ~hour_q[5];
        day_roll = hour_q[5];
      end
    end else begin
      hour_nxt = h24_nxt;
      day_roll = h24_wrap;
    end
  end

  // ******************************************************
  // AXI4-Lite write path
  // ******************************************************
  // Address and data are parked until both have arrived, in either order.
  // The pair is consumed only while the response slot is free.
  wire       wr_go;
  wire [7:0] wb;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wb    = w_data_q[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RTCTC_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q[7:2])
          `RTCTC_IDX_MIN, `RTCTC_IDX_HOUR, `RTCTC_IDX_WDAY, `RTCTC_IDX_MDAY,
          `RTCTC_IDX_MONTH, `RTCTC_IDX_YEAR, `RTCTC_IDX_CTRL:
            s_axi_bresp <= (wp && aw_addr_q[7:2] != `RTCTC_IDX_CTRL) ? `RTCTC_RESP_SLVERR
                                                                     : `RTCTC_RESP_OKAY;
          default: s_axi_bresp <= `RTCTC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ******************************************************
  // Time and calendar state
  // ******************************************************
  // A host write beats a tick in the same cycle for the written register, and a format switch also for the hour; other registers still take the tick.
  wire wr_ok;
  assign wr_ok = wr_go && w_strb_q[0] && !wp;
  always @(posedge aclk) begin
    if (!aresetn) begin
      min_q   <= `RTCTC_RST_MIN;
      hour_q  <= `RTCTC_RST_HOUR;
      wday_q  <= `RTCTC_RST_WDAY;
      mday_q  <= `RTCTC_RST_MDAY;
      month_q <= `RTCTC_RST_MONTH;
      year_q  <= `RTCTC_RST_YEAR;
      ctrl_q  <= 3'h0;
    end else begin
      if (minute_tick_q) begin
        min_q <= min_nxt;
        if (min_wrap) begin
          hour_q <= hour_nxt;
          if (day_roll) begin
            wday_q <= (wday_q >= 8'h06) ? 8'h00 : wday_q + 8'h01;
            mday_q <= mday_nxt;
            if (mday_wrap) begin
              month_q <= mon_nxt;
              if (mon_wrap)
                year_q <= yr_nxt;
            end
          end
        end
      end
      if (wr_go && w_strb_q[0] && aw_addr_q[7:2] == `RTCTC_IDX_CTRL) begin
        ctrl_q <= wb[2:0];
        // Switching format converts the hour so the count stays consistent.
        if (wb[`RTCTC_CTRL_H12_BIT] != h12)
          hour_q <= wb[`RTCTC_CTRL_H12_BIT] ? to12(hour_q) : to24(hour_q);
      end
      if (wr_ok) begin
        case (aw_addr_q[7:2])
          `RTCTC_IDX_MIN:   min_q   <= {1'b0, wb[6:0]};
          `RTCTC_IDX_HOUR:  hour_q  <= h12 ? {2'h0, wb[5:0]} : {2'h0, wb[5:0]};
          `RTCTC_IDX_WDAY:  wday_q  <= {5'h0, wb[2:0]};
          `RTCTC_IDX_MDAY:  mday_q  <= {2'h0, wb[5:0]};
          `RTCTC_IDX_MONTH: month_q <= {3'h0, wb[4:0]};
          `RTCTC_IDX_YEAR:  year_q  <= wb;
          default: ;
        endcase
      end
    end
  end

  // Hour code conversions; bit 5 of the 12-hour code marks the afternoon.
  function [7:0] to12;
    input [7:0] h;
    begin
      if (h == 8'h00)      to12 = 8'h12;
      else if (h < 8'h12)  to12 = h;
      else if (h == 8'h12) to12 = 8'h32;
      else if (h < 8'h22)  to12 = (h[3:0] >= 4'h2) ? {4'h2, h[3:0] - 4'h2} : {4'h2, h[3:0] + 4'h8};
      else                 to12 = {4'h3, h[3:0] - 4'h2};
    end
  endfunction

  function [7:0] to24;
    input [7:0] h;
    reg   [7:0] b;
    begin
      b = {3'h0, h[4:0]};
      if (!h[5])              to24 = (b == 8'h12) ? 8'h00 : b;
      else if (b == 8'h12)    to24 = 8'h12;
      else if (b[3:0] >= 4'h8) to24 = {4'h2, b[3:0] - 4'h8};
      else                    to24 = {b[7:4] + 4'h1, b[3:0] + 4'h2};
    end
  endfunction

  // ******************************************************
  // AXI4-Lite read path
  // ******************************************************
  // The byte is captured at the address handshake, so a tick that lands
  // while rvalid waits for rready cannot change the returned value.
  reg [7:0] rd_byte;
  reg       rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      `RTCTC_IDX_MIN:   rd_byte = min_q;
      `RTCTC_IDX_HOUR:  rd_byte = hour_q;
      `RTCTC_IDX_WDAY:  rd_byte = wday_q;
      `RTCTC_IDX_MDAY:  rd_byte = mday_q;
      `RTCTC_IDX_MONTH: rd_byte = month_q;
      `RTCTC_IDX_YEAR:  rd_byte = year_q;
      `RTCTC_IDX_CTRL:  rd_byte = {5'h0, ctrl_q};
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RTCTC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rd_byte};
        s_axi_rresp  <= rd_hit ? `RTCTC_RESP_OKAY : `RTCTC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rtctc_regs
`default_nettype wire

// [bench/rtctc_props.sv]
`timescale 1ns/100ps
`default_nettype none
module rtctc_props #(
  parameter [31:0] TICK_CYC = 32'h4
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timebase
  input wire logic        minute_tick_q
);
  logic [31:0] gap_q;
  logic        seen_q;
  logic [7:0]  addr_q;
  // The first tick after reset is skipped because its phase is not fixed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (minute_tick_q) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      addr_q <= s_axi_araddr;
    end
  end
  // ********
  // Checks.
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  tick_period_a: assert property (minute_tick_q && seen_q |-> gap_q == 60 * TICK_CYC - 1)
    else $error("minute tick spacing is wrong");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  minute_range_a: assert property (s_axi_rvalid && addr_q == 8'h04
    |-> s_axi_rdata[7:4] <= 4'h5 && s_axi_rdata[3:0] <= 4'h9) else $error("minutes out of range");
  weekday_range_a: assert property (s_axi_rvalid && addr_q == 8'h0C |-> s_axi_rdata <= 32'h6)
    else $error("weekday out of range");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (minute_tick_q && seen_q);
  cover property (s_axi_rvalid && s_axi_rready && addr_q == 8'h14);
endmodule // rtctc_props
bind rtctc_regs rtctc_props #(.TICK_CYC(TICK_CYC)) i_rtctc_props (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .minute_tick_q);
`default_nettype wire

// [bench/rtctc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module rtctc_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic [2:0]  s_axi_awprot,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  // Read channels
  output var  logic [7:0]  s_axi_araddr,
  output var  logic [2:0]  s_axi_arprot,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  logic hung = 1'b0;
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released address and data lines are inverted so stale values cannot pass as valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    bit ga;
    bit gw;
    {ga, gw, n} = '0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ga && gw) && n < 64) begin
      @(posedge aclk);
      n++;
      if (!ga && s_axi_awready) begin
        ga = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!gw && s_axi_wready) begin
        gw = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~{24'h0, d};
      end
    end
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 96);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 96) hung = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 64);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 96);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 96) hung = 1'b1;
  endtask
endmodule // rtctc_host
`default_nettype wire

// [bench/rtctc_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module rtctc_regs_tb_top;
  localparam int TICK_SIM = 4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, minute_tick_q;
  int          err_count = 0;
  int          n_compared = 0;
  rtctc_regs #(.TICK_CYC(TICK_SIM)) i_rtctc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .minute_tick_q);
  rtctc_host i_rtctc_host (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  initial forever #20 aclk = ~aclk;
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
    if (i_rtctc_host.hung) begin
      err_count++;
      $display("MISMATCH bus_handshake expected answer seen timeout");
      report_and_stop();
    end
  endtask
  task automatic wx(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_rtctc_host.wr(idx << 2, d, r);
    chk($sformatf("bresp %h", idx), {30'h0, er}, {30'h0, r});
  endtask
  task automatic rx(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_rtctc_host.rd(idx << 2, d, r);
    chk($sformatf("rresp %h", idx), {30'h0, er}, {30'h0, r});
    chk($sformatf("rdata %h", idx), {24'h0, ex}, d);
  endtask
  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (minute_tick_q !== 1'b1 && n < 400);
    if (n >= 400) err_count++;
    if (n >= 400) report_and_stop();
  endtask
  function automatic logic [7:0] inc(input logic [7:0] x);
    return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
  endfunction
  function automatic logic [7:0] last(input logic [7:0] mo, input logic [7:0] yr);
    if (mo == 8'h02) return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
    return (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) ? 8'h30 : 8'h31;
  endfunction
  function automatic logic [7:0] rb(input int lo, input int hi);
    int v;
    v = lo + $urandom % (hi - lo + 1);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  // Writes land just after a tick so that a whole minute separates them from the next carry.
  task automatic arm(input logic [7:0] mn, hr, wd, md, mo, yr);
    wait_tick();
    wx(8'h01, mn, 2'h0);
    wx(8'h02, hr, 2'h0);
    wx(8'h03, wd, 2'h0);
    wx(8'h06, yr, 2'h0);
    wx(8'h05, mo, 2'h0);
    wx(8'h04, md, 2'h0);
    wait_tick();
    repeat (4) @(posedge aclk);
  endtask
  task automatic roll(input logic [7:0] mn, hr, wd, md, mo, yr);
    logic c1, c2, c3;
    arm(mn, hr, wd, md, mo, yr);
    c1 = (mn == 8'h59);
    c2 = c1 && hr == 8'h23;
    c3 = c2 && md == last(mo, yr);
    rx(8'h01, c1 ? 8'h00 : inc(mn), 2'h0);
    rx(8'h02, c2 ? 8'h00 : c1 ? inc(hr) : hr, 2'h0);
    rx(8'h03, c2 ? (wd == 8'h06 ? 8'h00 : wd + 8'h01) : wd, 2'h0);
    rx(8'h04, c3 ? 8'h01 : c2 ? inc(md) : md, 2'h0);
    rx(8'h05, c3 ? (mo == 8'h12 ? 8'h01 : inc(mo)) : mo, 2'h0);
  endtask
  initial begin
    logic [7:0] m, y;
    void'($urandom(32'hEA7D));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 1; i < 4; i++) rx(8'(i), 8'h00, 2'h0);
    rx(8'h04, 8'h01, 2'h0);
    wait_tick();
    wx(8'h01, 8'hA5, 2'h0);
    rx(8'h01, 8'h25, 2'h0);
    wx(8'h02, 8'hD9, 2'h0);
    rx(8'h02, 8'h19, 2'h0);
    wx(8'h03, 8'hFB, 2'h0);
    rx(8'h03, 8'h03, 2'h0);
    wx(8'h04, 8'hC5, 2'h0);
    rx(8'h04, 8'h05, 2'h0);
    roll(8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99);
    roll(8'h59, 8'h23, 8'h02, 8'h28, 8'h02, 8'h24);
    roll(8'h59, 8'h23, 8'h00, 8'h29, 8'h02, 8'h00);
    roll(8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h23);
    for (int i = 0; i < 8; i++) begin
      m = rb(1, 12);
      y = rb(0, 99);
      roll(i[0] ? 8'h59 : rb(0, 58), i[1] ? 8'h23 : rb(0, 22), rb(0, 6), i[2] ? last(m, y) : rb(1, 28), m, y);
    end
    wx(8'h02, 8'h20, 2'h0);
    wx(8'h10, 8'h01, 2'h0);
    rx(8'h02, 8'h28, 2'h0);
    wx(8'h10, 8'h00, 2'h0);
    rx(8'h02, 8'h20, 2'h0);
    wx(8'h10, 8'h01, 2'h0);
    arm(8'h59, 8'h11, 8'h00, 8'h01, 8'h01, 8'h00);
    rx(8'h02, 8'h32, 2'h0);
    arm(8'h59, 8'h09, 8'h00, 8'h01, 8'h01, 8'h00);
    rx(8'h02, 8'h10, 2'h0);
    arm(8'h59, 8'h31, 8'h02, 8'h15, 8'h01, 8'h00);
    rx(8'h02, 8'h12, 2'h0);
    rx(8'h03, 8'h03, 2'h0);
    rx(8'h04, 8'h16, 2'h0);
    arm(8'h59, 8'h32, 8'h00, 8'h01, 8'h01, 8'h00);
    rx(8'h02, 8'h21, 2'h0);
    wx(8'h10, 8'h03, 2'h0);
    wx(8'h01, 8'h42, 2'h2);
    rx(8'h01, 8'h00, 2'h0);
    rx(8'h10, 8'h03, 2'h0);
    rx(8'h07, 8'h00, 2'h2);
    wx(8'h07, 8'h00, 2'h2);
    wx(8'h10, 8'h00, 2'h0);
    report_and_stop();
  end
endmodule // rtctc_regs_tb_top
`default_nettype wire
